// *** hw/serial_port_defines.svh ***
// Register offsets, field positions, reset values and counts for the serial port control block.
// Assumes inclusion by bare name from the package and the block.
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PORT_CTRL 8'h00
`define OFS_RATE_GEN 8'h04
`define OFS_RX_DATA 8'h08
`define OFS_TX_DATA 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_CLEAR 8'h14
`define OFS_IRQ_ENABLE 8'h18

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BIT_RX_RESET_N 0
`define BIT_RX_READY 1
`define BIT_RX_SYNC_ERR 3
`define POS_RX_IRQ_MODE 4
`define BIT_TX_RESET_N 16
`define BIT_TX_READY 17
`define BIT_TX_SYNC_ERR 19
`define POS_TX_IRQ_MODE 20
`define BIT_RATE_GEN_RESET_N 22
`define BIT_FSYNC_GEN_RESET_N 23
`define BIT_CLOCK_MASTER 24
`define POS_DIVIDER 0

// ----------------------------------------
// Interrupt status bits and reset values
// ----------------------------------------
`define IRQ_BITS 4
`define IRQ_RX_EVENT 0
`define IRQ_TX_EVENT 1
`define IRQ_RX_SYNC_ERR 2
`define IRQ_TX_SYNC_ERR 3
`define DIVIDER_RESET 8'h01
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define GEN_SYNC_PERIODS 2
`define SPURIOUS_EDGES 2

`endif

// *** hw/serial_port_pkg.sv ***
// Types shared by the serial port control block.
// Assumes the defines header is on the include path.
package serial_port_pkg;
   `include "serial_port_defines.svh"

   typedef enum logic [1:0] {IRQ_READY, IRQ_SUBFRAME, IRQ_FSYNC, IRQ_SYNCERR} irq_mode_e;
   typedef enum {GEN_IDLE, GEN_SYNC, GEN_RUN} gen_state_e;

   typedef struct packed {
      logic clockMaster;
      logic fsyncGenResetN;
      logic rateGenResetN;
      irq_mode_e txIrqMode;
      logic txResetN;
      irq_mode_e rxIrqMode;
      logic rxResetN;
   } port_ctrl_s;

   // Per-section core events, index 0 receive and 1 transmit
   typedef struct packed {
      logic [1:0] copy;
      logic [1:0] subframeEnd;
      logic [1:0] syncErr;
   } core_events_s;
endpackage

// *** hw/serial_port_irq_ctrl.sv ***
// Startup sequencing, ready flags, interrupts and DMA requests of a buffered serial port.
// Assumes an AXI4-Lite master, pins from another domain, and core events on this clock.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`include "serial_port_defines.svh"

module serial_port_irq_ctrl import serial_port_pkg::*; (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic rxBitClock,
   input wire logic txBitClock,
   input wire logic rxFrameSync,
   input wire logic txFrameSync,
   input wire core_events_s coreEvents,
   input wire logic [31:0] rxBufferData,
   output logic [31:0] txDataOut,
   output logic rxSectionResetN,
   output logic txSectionResetN,
   output logic generatedBitClock,
   output logic rxIrq,
   output logic txIrq,
   output logic rxDmaRequest,
   output logic txDmaRequest,
   output logic irq
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] pins;
   logic [3:0] pinS1_q, pinS2_q, pinS3_q, pinStable_q, pinStable_d, pinRise;
   assign pins = {txFrameSync, rxFrameSync, txBitClock, rxBitClock};
   genvar gp;
   generate
      for (gp = 0; gp < 4; gp++) begin : g_pin
         // Change counts only once the second and third stages agree
         always_comb begin
            pinStable_d[gp] = (pinS2_q[gp] == pinS3_q[gp]) ? pinS2_q[gp] : pinStable_q[gp];
            pinRise[gp] = pinStable_d[gp] & ~pinStable_q[gp];
         end
         always_ff @(posedge clock) begin
            if (!rstn) begin
               pinS1_q[gp] <= 1'b0;
               pinS2_q[gp] <= 1'b0;
               pinS3_q[gp] <= 1'b0;
               pinStable_q[gp] <= 1'b0;
            end else begin
               pinS1_q[gp] <= pins[gp];
               pinS2_q[gp] <= pinS1_q[gp];
               pinS3_q[gp] <= pinS2_q[gp];
               pinStable_q[gp] <= pinStable_d[gp];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   port_ctrl_s ctrl_q, ctrl_d;
   logic [7:0] divider_q, divider_d;
   logic [31:0] txData_q, txData_d, rxData_q, rxData_d;
   logic [`IRQ_BITS-1:0] status_q, status_d, enable_q, enable_d, clearBits;
   logic awHave_q, awHave_d, wHave_q, wHave_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [7:0] awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d, rdata_q, rdata_d, merged, ctrlWord;
   logic [3:0] wStrb_q, wStrb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic doWrite, rxRead, txWrite;
   logic [1:0] ready_q, ready_d, syncErr_q, syncErr_d, errSet, fsDet, secIrq, resetN;
   logic txFirst_q, txFirst_d, spurArmed_q, spurArmed_d, spurSet, bitEdge;
   logic [1:0] spurCnt_q, spurCnt_d;
   gen_state_e genState_q, genState_d;
   logic [7:0] genCnt_q, genCnt_d;
   logic genPeriods_q, genPeriods_d, genClk_q, genClk_d, genRise, genWrap;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = val[8*b +: 8];
         end
      end
      return res;
   endfunction

   always_comb begin
      ctrlWord = 32'h0;
      ctrlWord[`BIT_RX_RESET_N] = ctrl_q.rxResetN;
      ctrlWord[`BIT_RX_READY] = ready_q[0];
      ctrlWord[`BIT_RX_SYNC_ERR] = syncErr_q[0];
      ctrlWord[`POS_RX_IRQ_MODE +: 2] = ctrl_q.rxIrqMode;
      ctrlWord[`BIT_TX_RESET_N] = ctrl_q.txResetN;
      ctrlWord[`BIT_TX_READY] = ready_q[1];
      ctrlWord[`BIT_TX_SYNC_ERR] = syncErr_q[1];
      ctrlWord[`POS_TX_IRQ_MODE +: 2] = ctrl_q.txIrqMode;
      ctrlWord[`BIT_RATE_GEN_RESET_N] = ctrl_q.rateGenResetN;
      ctrlWord[`BIT_FSYNC_GEN_RESET_N] = ctrl_q.fsyncGenResetN;
      ctrlWord[`BIT_CLOCK_MASTER] = ctrl_q.clockMaster;
   end

   assign awready = !awHave_q && !bvalid_q;
   assign wready = !wHave_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign doWrite = awHave_q && wHave_q && !bvalid_q;
   assign rxRead = arvalid && arready && (araddr == `OFS_RX_DATA);
   assign txWrite = doWrite && (awAddr_q == `OFS_TX_DATA);

   always_comb begin
      awHave_d = awHave_q;
      awAddr_d = awAddr_q;
      wHave_d = wHave_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      bvalid_d = bvalid_q && !bready;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q && !rready;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      ctrl_d = ctrl_q;
      divider_d = divider_q;
      txData_d = txData_q;
      enable_d = enable_q;
      clearBits = '0;
      merged = 32'h0;
      if (awvalid && awready) begin
         awHave_d = 1'b1;
         awAddr_d = awaddr;
      end
      if (wvalid && wready) begin
         wHave_d = 1'b1;
         wData_d = wdata;
         wStrb_d = wstrb;
      end
      if (doWrite) begin
         awHave_d = 1'b0;
         wHave_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = `RESP_OKAY;
         case (awAddr_q)
            `OFS_PORT_CTRL: begin
               merged = mergeBytes(ctrlWord, wData_q, wStrb_q);
               ctrl_d.rxResetN = merged[`BIT_RX_RESET_N];
               ctrl_d.rxIrqMode = irq_mode_e'(merged[`POS_RX_IRQ_MODE +: 2]);
               ctrl_d.txResetN = merged[`BIT_TX_RESET_N];
               ctrl_d.txIrqMode = irq_mode_e'(merged[`POS_TX_IRQ_MODE +: 2]);
               ctrl_d.rateGenResetN = merged[`BIT_RATE_GEN_RESET_N];
               ctrl_d.fsyncGenResetN = merged[`BIT_FSYNC_GEN_RESET_N];
               ctrl_d.clockMaster = merged[`BIT_CLOCK_MASTER];
            end
            `OFS_RATE_GEN: begin
               merged = mergeBytes({24'h0, divider_q}, wData_q, wStrb_q);
               divider_d = merged[`POS_DIVIDER +: 8];
            end
            `OFS_TX_DATA: txData_d = mergeBytes(txData_q, wData_q, wStrb_q);
            `OFS_IRQ_CLEAR: clearBits = wData_q[`IRQ_BITS-1:0];
            `OFS_IRQ_ENABLE: enable_d = wData_q[`IRQ_BITS-1:0];
            `OFS_RX_DATA, `OFS_IRQ_STATUS: bresp_d = `RESP_OKAY;
            default: bresp_d = `RESP_SLVERR;
         endcase
      end
      if (arvalid && arready) begin
         rvalid_d = 1'b1;
         rresp_d = `RESP_OKAY;
         case (araddr)
            `OFS_PORT_CTRL: rdata_d = ctrlWord;
            `OFS_RATE_GEN: rdata_d = {24'h0, divider_q};
            `OFS_RX_DATA: rdata_d = rxData_q;
            `OFS_TX_DATA: rdata_d = txData_q;
            `OFS_IRQ_STATUS: rdata_d = {{(32-`IRQ_BITS){1'b0}}, status_q};
            `OFS_IRQ_CLEAR: rdata_d = 32'h0;
            `OFS_IRQ_ENABLE: rdata_d = {{(32-`IRQ_BITS){1'b0}}, enable_q};
            default: begin
               rdata_d = 32'h0;
               rresp_d = `RESP_SLVERR;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Ready flags, sync errors, spurious error
   // ----------------------------------------
   assign resetN = {ctrl_q.txResetN, ctrl_q.rxResetN};
   assign bitEdge = ctrl_q.clockMaster ? genRise : pinRise[1];
   assign errSet = {coreEvents.syncErr[1] | spurSet, coreEvents.syncErr[0]};

   always_comb begin
      rxData_d = coreEvents.copy[0] ? rxBufferData : rxData_q;
      // Receive ready: the copy wins over a read in the same cycle
      ready_d[0] = ctrl_q.rxResetN & ((ready_q[0] & ~rxRead) | coreEvents.copy[0]);
      if (ctrl_d.txResetN && !ctrl_q.txResetN) begin
         ready_d[1] = 1'b1;
      end else begin
         ready_d[1] = ctrl_q.txResetN & ((ready_q[1] & ~txWrite) | coreEvents.copy[1]);
      end
      // Only the first enable after device reset arms the spurious error window
      txFirst_d = txFirst_q;
      spurArmed_d = spurArmed_q && ctrl_q.txResetN;
      spurCnt_d = spurCnt_q;
      spurSet = 1'b0;
      if (ctrl_d.txResetN && !ctrl_q.txResetN && txFirst_q) begin
         txFirst_d = 1'b0;
         spurArmed_d = 1'b1;
         spurCnt_d = 2'h0;
      end else if (spurArmed_q && ctrl_q.txResetN && bitEdge) begin
         spurCnt_d = spurCnt_q + 2'h1;
         if (spurCnt_d == 2'(`SPURIOUS_EDGES)) begin
            spurSet = 1'b1;
            spurArmed_d = 1'b0;
         end
      end
      syncErr_d = resetN & (syncErr_q | errSet);
   end

   // ----------------------------------------
   // Rate generator
   // ----------------------------------------
   assign genWrap = (genCnt_q == divider_q);
   assign genRise = (genState_q == GEN_RUN) && (genCnt_q == 8'h0);

   always_comb begin
      genState_d = genState_q;
      genCnt_d = genWrap ? 8'h0 : genCnt_q + 8'h1;
      genPeriods_d = genPeriods_q;
      genClk_d = 1'b0;
      case (genState_q)
         GEN_IDLE: begin
            genCnt_d = 8'h0;
            genPeriods_d = 1'b0;
            if (ctrl_q.rateGenResetN) begin
               genState_d = GEN_SYNC;
            end
         end
         GEN_SYNC: begin
            // Two whole divided periods pass before the clock shows
            if (genWrap) begin
               genPeriods_d = 1'b1;
               if (genPeriods_q == 1'(`GEN_SYNC_PERIODS - 1)) begin
                  genState_d = GEN_RUN;
                  genClk_d = 1'b1;
               end
            end
         end
         GEN_RUN: genClk_d = (genCnt_d <= {1'b0, divider_q[7:1]});
         default: genState_d = GEN_IDLE;
      endcase
      if (!ctrl_q.rateGenResetN) begin
         genState_d = GEN_IDLE;
         genClk_d = 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupt mode multiplexers
   // ----------------------------------------
   genvar gs;
   generate
      for (gs = 0; gs < 2; gs++) begin : g_sec
         irq_mode_e mode;
         assign mode = (gs == 0) ? ctrl_q.rxIrqMode : ctrl_q.txIrqMode;
         assign fsDet[gs] = pinRise[2+gs] & resetN[gs];
         always_comb begin
            case (mode)
               IRQ_READY: secIrq[gs] = ready_q[gs];
               IRQ_SUBFRAME: secIrq[gs] = coreEvents.subframeEnd[gs] & resetN[gs];
               IRQ_FSYNC: secIrq[gs] = fsDet[gs];
               IRQ_SYNCERR: secIrq[gs] = errSet[gs] & resetN[gs];
               default: secIrq[gs] = 1'b0;
            endcase
         end
      end
   endgenerate

   // Set wins over a clear in the same cycle
   assign status_d = (status_q & ~clearBits) | {errSet & resetN, secIrq};

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctrl_q <= '0;
         divider_q <= `DIVIDER_RESET;
         txData_q <= 32'h0;
         rxData_q <= 32'h0;
         status_q <= '0;
         enable_q <= '0;
         awHave_q <= 1'b0;
         awAddr_q <= 8'h0;
         wHave_q <= 1'b0;
         wData_q <= 32'h0;
         wStrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0;
         ready_q <= 2'h0;
         syncErr_q <= 2'h0;
         txFirst_q <= 1'b1;
         spurArmed_q <= 1'b0;
         spurCnt_q <= 2'h0;
         genState_q <= GEN_IDLE;
         genCnt_q <= 8'h0;
         genPeriods_q <= 1'b0;
         genClk_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         divider_q <= divider_d;
         txData_q <= txData_d;
         rxData_q <= rxData_d;
         status_q <= status_d;
         enable_q <= enable_d;
         awHave_q <= awHave_d;
         awAddr_q <= awAddr_d;
         wHave_q <= wHave_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         syncErr_q <= syncErr_d;
         txFirst_q <= txFirst_d;
         spurArmed_q <= spurArmed_d;
         spurCnt_q <= spurCnt_d;
         genState_q <= genState_d;
         genCnt_q <= genCnt_d;
         genPeriods_q <= genPeriods_d;
         genClk_q <= genClk_d;
      end
   end

   assign bresp = bresp_q;
   assign bvalid = bvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign rvalid = rvalid_q;
   assign txDataOut = txData_q;
   assign rxSectionResetN = ctrl_q.rxResetN;
   assign txSectionResetN = ctrl_q.txResetN;
   assign generatedBitClock = genClk_q;
   assign rxIrq = secIrq[0];
   assign txIrq = secIrq[1];
   assign rxDmaRequest = ready_q[0];
   assign txDmaRequest = ready_q[1];
   assign irq = |(status_q & enable_q);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // Spurious window kept in a counter: the bit clock period has no bound
   logic winOpen_q, winOpen_d;
   logic [1:0] winEdges_q, winEdges_d;

   always_comb begin
      winOpen_d = winOpen_q && ctrl_q.txResetN;
      winEdges_d = winEdges_q;
      if (txFirst_q && !ctrl_q.txResetN && ctrl_d.txResetN) begin
         winOpen_d = 1'b1;
         winEdges_d = 2'h0;
      end else if (winOpen_q && ctrl_q.txResetN && bitEdge) begin
         winEdges_d = winEdges_q + 2'h1;
         winOpen_d = (winEdges_q == 2'h0);
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         winOpen_q <= 1'b0;
         winEdges_q <= 2'h0;
      end else begin
         winOpen_q <= winOpen_d;
         winEdges_q <= winEdges_d;
      end
   end

   sequence secondTxEdge;
      winOpen_q && ctrl_q.txResetN && bitEdge && winEdges_q == 2'h1;
   endsequence

   a_fsync_in_reset: assert property (!ctrl_q.txResetN && ctrl_q.txIrqMode == IRQ_FSYNC |-> !txIrq)
      else $error("tx frame-sync interrupt while section in reset");
   a_ready_mode_irq: assert property (ctrl_q.rxIrqMode == IRQ_READY |-> rxIrq == rxDmaRequest)
      else $error("rx interrupt does not follow ready flag");
   a_subframe_irq_out: assert property (ctrl_q.rxIrqMode == IRQ_SUBFRAME && ctrl_q.rxResetN && coreEvents.subframeEnd[0]
      && enable_q[`IRQ_RX_EVENT] |=> irq)
      else $error("subframe end did not raise interrupt");
   a_fsync_detect_irq: assert property (ctrl_q.txIrqMode == IRQ_FSYNC && ctrl_q.txResetN && pinS2_q[3] && pinS3_q[3]
      && !pinStable_q[3] |-> txIrq ##1 status_q[`IRQ_TX_EVENT])
      else $error("frame sync detection missed");
   a_syncerr_irq: assert property (ctrl_q.txIrqMode == IRQ_SYNCERR && ctrl_q.txResetN && coreEvents.syncErr[1]
      |-> txIrq ##1 syncErr_q[1])
      else $error("sync error did not raise tx interrupt");
   a_syncerr_sticky: assert property (syncErr_q[0] && ctrl_q.rxResetN |=> syncErr_q[0])
      else $error("rx sync error flag lost");
   a_rx_read_clears: assert property (rxRead && !coreEvents.copy[0] |=> !ready_q[0] && !rxDmaRequest)
      else $error("rx read did not clear ready");
   a_tx_ready_seq: assert property (!ctrl_q.txResetN && ctrl_d.txResetN |=> ready_q[1] ##0 txDmaRequest)
      else $error("tx ready not raised on leaving reset");
   a_tx_write_clears: assert property (txWrite && !coreEvents.copy[1] && ctrl_q.txResetN |=> !ready_q[1])
      else $error("tx data write did not clear ready");
   a_gen_first_high: assert property (genState_q == GEN_SYNC ##1 genState_q == GEN_RUN |-> genClk_q)
      else $error("generated clock not high on start");
   a_spurious_window: assert property (secondTxEdge |=> syncErr_q[1])
      else $error("spurious tx sync error not flagged in window");
   a_tx_reset_clears: assert property (!ctrl_q.txResetN && !ctrl_d.txResetN |=> !syncErr_q[1] [*2])
      else $error("tx sync error survives reset");
endmodule

// *** test/serial_far_end.sv ***
// Far-end serial device model: drives bit clock and frame sync for both sections.
// Assumes bits() is called just after a rising edge of clock.
`timescale 1ns/100ps

module serial_far_end (
   input wire logic clock,
   output logic bitClock,
   output logic frameSync
);
   // Bit clock stands still low between frames
   initial begin
      bitClock = 1'b0;
      frameSync = 1'b0;
   end

   // Device owns both clock and sync, so pin function may be switched safely
   task automatic bits(input int cnt, input logic sync);
      for (int i = 0; i < cnt; i++) begin
         repeat (2) @(posedge clock);
         bitClock <= 1'b1;
         frameSync <= sync && i == 0;
         repeat (2) @(posedge clock);
         bitClock <= 1'b0;
      end
      frameSync <= 1'b0;
   endtask
endmodule

// *** test/serial_port_irq_ctrl_tb.sv ***
// Bench for the serial port control block: bus tasks and interrupt scenarios.
// Assumes the far-end model drives both sections' bit clock and frame sync pins.
`timescale 1ns/100ps
`include "serial_port_defines.svh"

module serial_port_irq_ctrl_tb import serial_port_pkg::*;;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rxBufferData = 32'h0;
   logic [3:0] wstrb = 4'hf;
   core_events_s coreEvents = '0;
   logic awready, wready, bvalid, arready, rvalid, bitClock, frameSync;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, txDataOut, rd;
   logic rxSectionResetN, txSectionResetN, generatedBitClock, rxIrq, txIrq, rxDmaRequest, txDmaRequest, irq;
   int failures = 0, cmpCount = 0, rxCnt = 0, txCnt = 0, r0, t0, n;

   always #4 clock = ~clock;

   serial_port_irq_ctrl u_serial_port_irq_ctrl (.clock, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .rxBitClock(bitClock), .txBitClock(bitClock), .rxFrameSync(frameSync), .txFrameSync(frameSync),
      .coreEvents, .rxBufferData, .txDataOut, .rxSectionResetN, .txSectionResetN, .generatedBitClock,
      .rxIrq, .txIrq, .rxDmaRequest, .txDmaRequest, .irq);
   serial_far_end u_serial_far_end (.clock, .bitClock, .frameSync);

   // Pulse modes give one-cycle pulses; counted off the edge to avoid races
   always @(negedge clock) begin
      if (rxIrq === 1'b1) rxCnt++;
      if (txIrq === 1'b1) txCnt++;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic close_out();
      $display("Compares %0d, mismatches %0d", cmpCount, failures);
      if (failures == 0 && cmpCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Handshakes sampled mid-cycle: registers only move on the rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic awTaken, wTaken, done;
      awTaken = 1'b0;
      wTaken = 1'b0;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge clock);
         if (awvalid && awready) awTaken = 1'b1;
         if (wvalid && wready) wTaken = 1'b1;
         done = bvalid;
         resp = bresp;
         @(posedge clock);
         if (awTaken) awvalid <= 1'b0;
         if (wTaken) wvalid <= 1'b0;
         if (done) begin
            bready <= 1'b0;
            break;
         end
      end
      if (n == 50) begin
         failures++;
         close_out();
      end
   endtask

   task automatic rdr(input logic [7:0] a);
      logic arTaken, done;
      arTaken = 1'b0;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge clock);
         if (arvalid && arready) arTaken = 1'b1;
         done = rvalid;
         rd = rdata;
         resp = rresp;
         @(posedge clock);
         if (arTaken) arvalid <= 1'b0;
         if (done) begin
            rready <= 1'b0;
            break;
         end
      end
      if (n == 50) begin
         failures++;
         close_out();
      end
   endtask

   task automatic ev(input logic [5:0] e);
      @(posedge clock);
      coreEvents <= core_events_s'(e);
      @(posedge clock);
      coreEvents <= '0;
      repeat (3) @(negedge clock);
   endtask

   function automatic logic [31:0] ctl(input irq_mode_e rm, input irq_mode_e tm, input logic rOn, input logic tOn);
      ctl = 32'h0;
      ctl[`POS_RX_IRQ_MODE +: 2] = rm;
      ctl[`POS_TX_IRQ_MODE +: 2] = tm;
      ctl[`BIT_RX_RESET_N] = rOn;
      ctl[`BIT_TX_RESET_N] = tOn;
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      rdr(`OFS_PORT_CTRL);
      chk(rd, 32'h0);
      rdr(`OFS_RATE_GEN);
      chk(rd, 32'(`DIVIDER_RESET));
      rdr(8'h1c);
      chk({rd[29:0], resp}, 32'(`RESP_SLVERR));
      wr(8'h1c, 32'h0);
      chk(resp, 32'(`RESP_SLVERR));
      // Program with every reset still low
      wr(`OFS_PORT_CTRL, ctl(IRQ_FSYNC, IRQ_FSYNC, 1'b0, 1'b0));
      chk(resp, 32'(`RESP_OKAY));
      r0 = rxCnt;
      t0 = txCnt;
      // First sync seen in reset; its clocks give the settle time
      u_serial_far_end.bits(3, 1'b1);
      repeat (6) @(negedge clock);
      chk(rxCnt - r0, 0);
      chk(txCnt - t0, 0);
      // Release only after the first sync; request lines already watched
      wr(`OFS_PORT_CTRL, ctl(IRQ_FSYNC, IRQ_SYNCERR, 1'b1, 1'b1));
      rdr(`OFS_PORT_CTRL);
      chk(rd[`BIT_TX_READY], 1'b1);
      @(negedge clock);
      chk(txDmaRequest, 1'b1);
      t0 = txCnt;
      u_serial_far_end.bits(3, 1'b0);
      repeat (6) @(negedge clock);
      chk(txCnt - t0, 1);
      rdr(`OFS_PORT_CTRL);
      chk(rd[`BIT_TX_SYNC_ERR], 1'b1);
      r0 = rxCnt;
      u_serial_far_end.bits(2, 1'b1);
      repeat (6) @(negedge clock);
      chk(rxCnt - r0, 1);
      r0 = rxCnt;
      t0 = txCnt;
      ev(6'h03);
      chk(txCnt - t0, 1);
      rdr(`OFS_PORT_CTRL);
      chk(rd[`BIT_RX_SYNC_ERR], 1'b1);
      chk(rxCnt - r0, 0);
      wr(`OFS_PORT_CTRL, ctl(IRQ_FSYNC, IRQ_SYNCERR, 1'b1, 1'b0));
      rdr(`OFS_PORT_CTRL);
      chk(rd[`BIT_TX_SYNC_ERR], 1'b0);
      chk({rxSectionResetN, txSectionResetN}, 2'b10);
      // Swap the pulse modes so each section sees both
      wr(`OFS_PORT_CTRL, ctl(IRQ_SYNCERR, IRQ_FSYNC, 1'b1, 1'b1));
      r0 = rxCnt;
      t0 = txCnt;
      u_serial_far_end.bits(2, 1'b1);
      repeat (6) @(negedge clock);
      chk(txCnt - t0, 1);
      ev(6'h01);
      chk(rxCnt - r0, 1);
      wr(`OFS_PORT_CTRL, ctl(IRQ_READY, IRQ_READY, 1'b1, 1'b1));
      @(negedge clock);
      chk({rxIrq, txIrq}, 2'b01);
      @(posedge clock);
      rxBufferData <= 32'hc3c3_3c3c;
      ev(6'h10);
      chk({rxIrq, rxDmaRequest}, 2'b11);
      rdr(`OFS_RX_DATA);
      chk(rd, 32'hc3c3_3c3c);
      @(negedge clock);
      chk({rxIrq, rxDmaRequest}, 2'b00);
      wr(`OFS_TX_DATA, 32'h0123_4567);
      @(negedge clock);
      chk({txIrq, txDmaRequest}, 2'b00);
      chk(txDataOut, 32'h0123_4567);
      ev(6'h20);
      chk({txIrq, txDmaRequest}, 2'b11);
      wr(`OFS_PORT_CTRL, ctl(IRQ_SUBFRAME, IRQ_SUBFRAME, 1'b1, 1'b1));
      r0 = rxCnt;
      t0 = txCnt;
      ev(6'h0c);
      chk(rxCnt - r0, 1);
      chk(txCnt - t0, 1);
      wr(`OFS_IRQ_CLEAR, 32'hf);
      wr(`OFS_IRQ_ENABLE, 32'hf);
      rdr(`OFS_IRQ_STATUS);
      chk({rd[30:0], irq}, 32'h0);
      ev(6'h06);
      rdr(`OFS_IRQ_STATUS);
      chk({rd[30:0], irq}, 32'h13);
      wr(`OFS_IRQ_ENABLE, 32'h0);
      @(negedge clock);
      chk(irq, 1'b0);
      // Divider 3 with rate generator and clock master bits set
      wr(`OFS_RATE_GEN, 32'h3);
      wr(`OFS_PORT_CTRL, ctl(IRQ_SUBFRAME, IRQ_SUBFRAME, 1'b1, 1'b1) | 32'h0140_0000);
      for (t0 = 0; t0 < 40 && generatedBitClock !== 1'b1; t0++) begin
         @(negedge clock);
      end
      chk(t0 >= 6 && t0 <= 10, 1'b1);
      for (r0 = 0; r0 < 40 && generatedBitClock === 1'b1; r0++) begin
         @(negedge clock);
      end
      for (n = 0; n < 40 && generatedBitClock !== 1'b1; n++) begin
         @(negedge clock);
      end
      chk(r0 + n, 4);
      close_out();
   end
endmodule
